// ==== asr_rx_monitor.sv ====
// Bus handshake and timer pacing checks for the serial receiver.
`timescale 1ns/1ns
`default_nettype none
module asr_rx_monitor (
	// Clock and reset.
	input wire logic        clk,
	input wire logic        rstn,
	// Bus handshakes.
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	// Timer output pin.
	input wire logic        timer_toggle_output
);
	// One clock domain, so every check rests while reset is low.
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);
	aw_block_a: assert property (s_axi_awvalid && s_axi_awready
		|=> !s_axi_awready) else $error("aw ready held after take");
	b_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
		s_axi_wvalid && s_axi_wready |-> ##[2:3] s_axi_bvalid)
		else $error("write answer late");
	b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b moved");
	b_release_a: assert property (s_axi_bvalid && s_axi_bready
		|=> !s_axi_bvalid) else $error("b not released");
	r_answer_a: assert property (s_axi_arvalid && s_axi_arready
		|-> ##[1:2] s_axi_rvalid) else $error("read answer late");
	r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r moved");
	r_refuse_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
		|-> s_axi_rdata == 32'h0) else $error("refused read data");
	// Timer input rises at most every twelve clocks, so one match each.
	toggle_pace_a: assert property ($changed(timer_toggle_output)
		|=> $stable(timer_toggle_output)[*8]) else $error("toggle fast");
endmodule // asr_rx_monitor
bind asr_rx_top asr_rx_monitor u_mon (.clk(clk), .rstn(rstn),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready),
	.timer_toggle_output(timer_toggle_output));
`default_nettype wire

// ==== asr_rx_partner.sv ====
// Remote asynchronous sender that drives the receive line.
`timescale 1ns/1ns
`default_nettype none
module asr_rx_partner (
	// Clock.
	input  wire logic clk,
	// Receive line, idle high.
	output var logic  txd
);
	initial txd = 1'b1;
	// Sends one frame; p is none, even or odd parity, m picks a fault.
	// Faults 1 to 3 are a low stop bit, a wrong parity bit, a short start.
	task send(input [7:0] d, input integer bt, input [1:0] p, m);
		logic   [10:0] f;
		integer        i;
		begin
			f = {1'b1, (^d) ^ (p == 2) ^ (m == 2), d, 1'b0};
			f[p != 0 ? 10 : 9] = m != 1;
			@(posedge clk);
			if (m == 3) begin
				txd <= 1'b0;
				repeat (bt * 3 / 8) @(posedge clk);
			end else begin
				for (i = 0; i < (p != 0 ? 11 : 10); i++) begin
					txd <= f[i]; // Start bits last a full bit.
					repeat (bt) @(posedge clk);
				end
			end
			txd <= 1'b1;
			repeat (bt * 2) @(posedge clk);
		end
	endtask
endmodule // asr_rx_partner
`default_nettype wire

// ==== asr_rx_regs.vh ====
// Register map, field positions and reset values of the serial receiver.
`ifndef ASR_RX_REGS_VH
`define ASR_RX_REGS_VH
// Byte offsets of the AXI4-Lite registers.
`define ASR_OFS_CTRL     8'h00
`define ASR_OFS_BAUD     8'h04
`define ASR_OFS_TCMP     8'h08
`define ASR_OFS_DATA     8'h0C
`define ASR_OFS_STAT     8'h10
`define ASR_OFS_ISTAT    8'h14
`define ASR_OFS_ICLR     8'h18
`define ASR_OFS_IEN      8'h1C
`define ASR_OFS_PORT     8'h20
// Control register fields.
`define ASR_CTRL_RXEN    0
`define ASR_CTRL_SRC_LO  1
`define ASR_CTRL_SRC_HI  2
`define ASR_CTRL_RATE_LO 3
`define ASR_CTRL_RATE_HI 4
`define ASR_CTRL_PAREN   5
`define ASR_CTRL_PARODD  6
`define ASR_CTRL_PIN2SEL 7
// Shift clock sources.
`define ASR_SRC_INT      2'h0
`define ASR_SRC_EXT      2'h1
`define ASR_SRC_TMR      2'h2
// Status register fields.
`define ASR_ST_READY     0
`define ASR_ST_ERR       1
`define ASR_ST_FRAME     2
`define ASR_ST_PARITY    3
`define ASR_ST_OVERRUN   4
`define ASR_ST_FALSE     5
`define ASR_ST_UNTRUST   6
// Interrupt status, clear and enable fields.
`define ASR_IRQ_RX       0
`define ASR_IRQ_ERR      1
`define ASR_IRQ_FALSE    2
// Reset values.
`define ASR_RST_CTRL     8'h00
`define ASR_RST_BAUD     16'h0043
`define ASR_RST_TCMP     8'h01
// AXI responses.
`define ASR_RESP_OKAY    2'h0
`define ASR_RESP_SLVERR  2'h2
`endif

// ==== asr_rx_top.v ====
// Asynchronous serial receiver with selectable shift clock and AXI4-Lite.
`timescale 1ns/1ns
`default_nettype none
`include "asr_rx_regs.vh"
module asr_rx_top #(
	parameter DIVW = 16		// Width of the internal baud divider.
) (
	// Clock and reset.
	input  wire        clk,
	input  wire        rstn,
	// AXI4-Lite write channels.
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// AXI4-Lite read channels.
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// Serial line and clock pins.
	input  wire        rxd,
	input  wire        sck_in,
	input  wire        timer_count_input,
	output reg         timer_toggle_output,
	// Port C pin 2 drive.
	output reg         port_c_pin2_out,
	output reg         port_c_pin2_oe,
	// Interrupt.
	output reg         irq
);
	// One-hot receiver states.
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_START = 5'h02;
	localparam [4:0] S_DATA = 5'h04;
	localparam [4:0] S_PAR = 5'h08;
	localparam [4:0] S_STOP = 5'h10;

	// Ticks per bit, the clock rate divisor N.
	function [6:0] rate_n;
		input [1:0] sel;
		begin
			case (sel)
			2'h0: rate_n = 7'h01;
			2'h1: rate_n = 7'h10;
			default: rate_n = 7'h40;
			endcase
		end
	endfunction

	// Merge a write into a register under the byte strobes.
	function [31:0] bmerge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0]  strb;
		integer i;
		begin
			bmerge = old;
			for (i = 0; i < 4; i = i + 1)
				if (strb[i])
					bmerge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	// Software registers.
	reg [7:0]      ctrl_q;		// Enable, source, rate, parity, pin 2.
	reg [DIVW-1:0] baud_q;		// Internal divider terminal count.
	reg [7:0]      tcmp_q;		// Timer 0 compare value C.
	reg [1:0]      port_q;		// Pin 2 port data and direction.
	reg [2:0]      ien_q;		// Interrupt enables.
	reg [2:0]      ist_q;		// Sticky interrupt status.
	// Receiver state and results.
	reg [4:0]      st_q;		// Receiver state, one-hot.
	reg [6:0]      tcnt_q;		// Ticks within the current bit.
	reg [2:0]      bcnt_q;		// Data bit index.
	reg [7:0]      sh_q;		// Shift register.
	reg [7:0]      data_q;		// Last received byte.
	reg            ready_q;		// Byte waiting to be read.
	reg            err_q;		// Sticky receive_error_flag.
	reg            ferr_q;		// Framing error seen.
	reg            perr_q;		// Parity error seen.
	reg            oerr_q;		// Overrun seen.
	reg            fstart_q;	// False start rejected.
	reg            par_q;		// Sampled parity bit.
	// Clock sources.
	reg [DIVW-1:0] div_q;		// Internal divider count.
	reg            iclk_q;		// Internal shift clock level.
	reg            sck_prev_q;	// Previous external clock level.
	reg            ti_prev_q;	// Previous timer input level.
	reg [7:0]      tm_q;		// Timer 0 pulse count.
	reg            rxd_prev_q;	// Previous line level.
	// AXI holding state.
	reg            aw_have_q;
	reg [7:0]      aw_addr_q;
	reg            w_have_q;
	reg [31:0]     w_data_q;
	reg [3:0]      w_strb_q;

	// Shorthand for control fields.
	wire [1:0] src = ctrl_q[`ASR_CTRL_SRC_HI:`ASR_CTRL_SRC_LO];
	wire [6:0] nbit = rate_n(ctrl_q[`ASR_CTRL_RATE_HI:`ASR_CTRL_RATE_LO]);
	wire [6:0] half = {1'b0, nbit[6:1]};
	wire       rxen = ctrl_q[`ASR_CTRL_RXEN];

	// Shift clock ticks from each source.
	// Compared with at-or-above so that lowering the divider while the
	// count is past the new value restarts it at once, not after a wrap.
	wire tick_int = (div_q >= baud_q);
	wire tick_ext = sck_in & ~sck_prev_q;
	// The timer input is edge-detected with no filter, so each level must
	// be held long enough for one sample; the bench guarantees that.
	wire ti_rise = timer_count_input & ~ti_prev_q;
	// Match after C input pulses; a compare value of zero means 256.
	wire tm_match = ti_rise & (tm_q == tcmp_q - 8'h01);
	// One tick per full period of the toggled output gives fTI/(2C).
	wire tick_tmr = tm_match & ~timer_toggle_output;
	wire tick = (src == `ASR_SRC_INT) ? tick_int :
		(src == `ASR_SRC_EXT) ? tick_ext :
		(src == `ASR_SRC_TMR) ? tick_tmr : 1'b0;
	wire bit_end = tick & (tcnt_q == nbit - 7'h01);

	// AXI handshake terms.
	wire aw_take = s_axi_awvalid & s_axi_awready;
	wire w_take = s_axi_wvalid & s_axi_wready;
	wire wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;
	wire ar_take = s_axi_arvalid & s_axi_arready;
	wire aw_have_d = aw_take | (aw_have_q & ~wr_fire);
	wire w_have_d = w_take | (w_have_q & ~wr_fire);
	wire bvalid_d = wr_fire | (s_axi_bvalid & ~s_axi_bready);
	wire rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
	wire wr_stat = wr_fire & (aw_addr_q == `ASR_OFS_STAT);
	wire wr_iclr = wr_fire & (aw_addr_q == `ASR_OFS_ICLR);
	wire rd_data = ar_take & (s_axi_araddr == `ASR_OFS_DATA);
	// Merged write values, one per writable register.
	wire [31:0] m_ctrl = bmerge({24'h0, ctrl_q}, w_data_q, w_strb_q);
	wire [31:0] m_baud = bmerge({{(32-DIVW){1'b0}}, baud_q},
		w_data_q, w_strb_q);
	wire [31:0] m_tcmp = bmerge({24'h0, tcmp_q}, w_data_q, w_strb_q);
	wire [31:0] m_ien = bmerge({29'h0, ien_q}, w_data_q, w_strb_q);
	wire [31:0] m_port = bmerge({30'h0, port_q}, w_data_q, w_strb_q);

	// Receiver events of this cycle.
	reg       ev_rx;
	reg       ev_ferr;
	reg       ev_perr;
	reg       ev_oerr;
	reg       ev_false;
	always @* begin
		ev_rx = st_q[4] & bit_end;
		ev_ferr = ev_rx & ~rxd;
		ev_perr = ev_rx & ctrl_q[`ASR_CTRL_PAREN] &
			((^sh_q) ^ par_q ^ ctrl_q[`ASR_CTRL_PARODD]);
		ev_oerr = ev_rx & ready_q & ~rd_data;
		ev_false = st_q[1] & tick & (tcnt_q == half) & rxd;
	end
	wire ev_err = ev_ferr | ev_perr | ev_oerr;

	// Read multiplexer; unmapped offsets answer zero with SLVERR.
	reg [31:0] rmux;
	reg        rbad;
	always @* begin
		rmux = 32'h0000_0000;
		rbad = 1'b0;
		case (s_axi_araddr)
		`ASR_OFS_CTRL: rmux[7:0] = ctrl_q;
		`ASR_OFS_BAUD: rmux[DIVW-1:0] = baud_q;
		`ASR_OFS_TCMP: rmux[7:0] = tcmp_q;
		`ASR_OFS_DATA: rmux[7:0] = data_q;
		`ASR_OFS_STAT: begin
			rmux[`ASR_ST_READY] = ready_q;
			rmux[`ASR_ST_ERR] = err_q;
			rmux[`ASR_ST_FRAME] = ferr_q;
			rmux[`ASR_ST_PARITY] = perr_q;
			rmux[`ASR_ST_OVERRUN] = oerr_q;
			rmux[`ASR_ST_FALSE] = fstart_q;
			// With an outside shift clock the error flag may not follow
			// the real outcome, so software is told not to trust it.
			rmux[`ASR_ST_UNTRUST] = (src == `ASR_SRC_EXT);
		end
		`ASR_OFS_ISTAT: rmux[2:0] = ist_q;
		`ASR_OFS_ICLR: rmux = 32'h0000_0000;
		`ASR_OFS_IEN: rmux[2:0] = ien_q;
		`ASR_OFS_PORT: rmux[1:0] = port_q;
		default: rbad = 1'b1;
		endcase
	end

	// AXI channel handshakes and the register writes they carry.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ASR_RESP_OKAY;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `ASR_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			aw_have_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_have_q <= 1'b0;
			w_data_q <= 32'h0000_0000;
			w_strb_q <= 4'h0;
			ctrl_q <= `ASR_RST_CTRL;
			baud_q <= `ASR_RST_BAUD;
			tcmp_q <= `ASR_RST_TCMP;
			port_q <= 2'h0;
			ien_q <= 3'h0;
		end else begin
			// Each channel is held off while its item waits or the
			// response is still pending.
			s_axi_awready <= ~aw_have_d & ~bvalid_d;
			s_axi_wready <= ~w_have_d & ~bvalid_d;
			s_axi_arready <= ~rvalid_d;
			s_axi_bvalid <= bvalid_d;
			s_axi_rvalid <= rvalid_d;
			aw_have_q <= aw_have_d;
			w_have_q <= w_have_d;
			if (aw_take)
				aw_addr_q <= s_axi_awaddr;
			if (w_take) begin
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			if (ar_take) begin
				s_axi_rdata <= rmux;
				s_axi_rresp <= rbad ? `ASR_RESP_SLVERR : `ASR_RESP_OKAY;
			end
			if (wr_fire) begin
				s_axi_bresp <= `ASR_RESP_OKAY;
				case (aw_addr_q)
				`ASR_OFS_CTRL: ctrl_q <= m_ctrl[7:0];
				`ASR_OFS_BAUD: baud_q <= m_baud[DIVW-1:0];
				`ASR_OFS_TCMP: tcmp_q <= m_tcmp[7:0];
				`ASR_OFS_IEN: ien_q <= m_ien[2:0];
				`ASR_OFS_PORT: port_q <= m_port[1:0];
				`ASR_OFS_DATA, `ASR_OFS_STAT, `ASR_OFS_ISTAT,
				`ASR_OFS_ICLR: s_axi_bresp <= `ASR_RESP_OKAY;
				default: s_axi_bresp <= `ASR_RESP_SLVERR;
				endcase
			end
		end
	end

	// Shift clock generation: internal divider and timer 0.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			div_q <= {DIVW{1'b0}};
			iclk_q <= 1'b0;
			sck_prev_q <= 1'b0;
			ti_prev_q <= 1'b0;
			tm_q <= 8'h00;
			timer_toggle_output <= 1'b0;
		end else begin
			sck_prev_q <= sck_in;
			ti_prev_q <= timer_count_input;
			// The divider free-runs so the pin 2 clock keeps its shape.
			if (tick_int) begin
				div_q <= {DIVW{1'b0}};
				iclk_q <= ~iclk_q;
			end else
				div_q <= div_q + {{(DIVW-1){1'b0}}, 1'b1};
			// Timer 0 counts input pulses only when it feeds the
			// receiver, and toggles its output on every match.
			if (src != `ASR_SRC_TMR) begin
				tm_q <= 8'h00;
			end else if (tm_match) begin
				tm_q <= 8'h00;
				timer_toggle_output <= ~timer_toggle_output;
			end else if (ti_rise)
				tm_q <= tm_q + 8'h01;
		end
	end

	// Receive state machine with mid-bit sampling.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= S_IDLE;
			tcnt_q <= 7'h00;
			bcnt_q <= 3'h0;
			sh_q <= 8'h00;
			par_q <= 1'b0;
			rxd_prev_q <= 1'b1;
		end else begin
			rxd_prev_q <= rxd;
			case (st_q)
			S_IDLE: begin
				tcnt_q <= 7'h00;
				bcnt_q <= 3'h0;
				if (rxen & rxd_prev_q & ~rxd)
					st_q <= S_START;
			end
			S_START: begin
				// The start bit is checked again at its middle; a pulse
				// shorter than half a bit is high there and is dropped
				// rather than taken as a character.
				if (tick & (tcnt_q == half)) begin
					tcnt_q <= 7'h00;
					st_q <= rxd ? S_IDLE : S_DATA;
				end else if (tick)
					tcnt_q <= tcnt_q + 7'h01;
			end
			S_DATA: begin
				if (bit_end) begin
					tcnt_q <= 7'h00;
					sh_q <= {rxd, sh_q[7:1]};
					bcnt_q <= bcnt_q + 3'h1;
					if (bcnt_q == 3'h7)
						st_q <= ctrl_q[`ASR_CTRL_PAREN] ? S_PAR : S_STOP;
				end else if (tick)
					tcnt_q <= tcnt_q + 7'h01;
			end
			S_PAR: begin
				if (bit_end) begin
					tcnt_q <= 7'h00;
					par_q <= rxd;
					st_q <= S_STOP;
				end else if (tick)
					tcnt_q <= tcnt_q + 7'h01;
			end
			S_STOP: begin
				if (bit_end)
					st_q <= S_IDLE;
				else if (tick)
					tcnt_q <= tcnt_q + 7'h01;
			end
			default: st_q <= S_IDLE;
			endcase
			// Disabling reception abandons any character in flight.
			if (!rxen)
				st_q <= S_IDLE;
		end
	end

	// Received byte, error flags and interrupt status; sets beat clears.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			data_q <= 8'h00;
			ready_q <= 1'b0;
			err_q <= 1'b0;
			ferr_q <= 1'b0;
			perr_q <= 1'b0;
			oerr_q <= 1'b0;
			fstart_q <= 1'b0;
			ist_q <= 3'h0;
			irq <= 1'b0;
		end else begin
			if (ev_rx) begin
				data_q <= sh_q;
				ready_q <= 1'b1;
			end else if (rd_data)
				ready_q <= 1'b0;
			// Error bits stay set until software writes ones to the
			// status register; a new error in that cycle wins.
			err_q <= ev_err |
				(err_q & ~(wr_stat & w_data_q[`ASR_ST_ERR]));
			ferr_q <= ev_ferr |
				(ferr_q & ~(wr_stat & w_data_q[`ASR_ST_FRAME]));
			perr_q <= ev_perr |
				(perr_q & ~(wr_stat & w_data_q[`ASR_ST_PARITY]));
			oerr_q <= ev_oerr |
				(oerr_q & ~(wr_stat & w_data_q[`ASR_ST_OVERRUN]));
			fstart_q <= ev_false |
				(fstart_q & ~(wr_stat & w_data_q[`ASR_ST_FALSE]));
			// The error event feeds the interrupt so software can ask
			// the sender to repeat the character.
			ist_q[`ASR_IRQ_RX] <= ev_rx |
				(ist_q[`ASR_IRQ_RX] & ~(wr_iclr & w_data_q[`ASR_IRQ_RX]));
			ist_q[`ASR_IRQ_ERR] <= ev_err |
				(ist_q[`ASR_IRQ_ERR] & ~(wr_iclr & w_data_q[`ASR_IRQ_ERR]));
			ist_q[`ASR_IRQ_FALSE] <= ev_false | (ist_q[`ASR_IRQ_FALSE] &
				~(wr_iclr & w_data_q[`ASR_IRQ_FALSE]));
			irq <= |(ist_q & ien_q);
		end
	end

	// Pin 2 drive: the internal clock goes out only when selected and
	// internal; with the select bit clear the pin stays a port.
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			port_c_pin2_out <= 1'b0;
			port_c_pin2_oe <= 1'b0;
		end else if (ctrl_q[`ASR_CTRL_PIN2SEL]) begin
			port_c_pin2_out <= iclk_q;
			port_c_pin2_oe <= (src == `ASR_SRC_INT);
		end else begin
			port_c_pin2_out <= port_q[0];
			port_c_pin2_oe <= port_q[1];
		end
	end
endmodule // asr_rx_top
`default_nettype wire

// ==== async_serial_receiver_clocking_tb_top.sv ====
// Self-checking bench for the serial receiver with a remote sender.
`timescale 1ns/1ns
`default_nettype none
module async_serial_receiver_clocking_tb_top;
	// Driven inputs start at rest; the line comes from the sender.
	logic clk = 0, rstn = 0, awvalid = 0, wvalid = 0, bready = 0;
	logic arvalid = 0, rready = 0, ti = 0, ka, kw, ks;
	logic   [7:0]  awaddr = 0, araddr = 0;
	logic   [31:0] wdata = 0, rs = 32'h0001_6B88;
	logic   [73:0] e, ex_q[$];
	logic   [1:0]  be_q[$];
	wire           awready, wready, bvalid, arready, rvalid, rxd;
	wire           tto, p2o, p2e, irq;
	wire    [1:0]  bresp, rresp;
	wire    [31:0] rdata;
	integer        error_cnt = 0, n_tests = 0, cyc = 0, bt = 16, k;
	asr_rx_top DUT (.clk(clk), .rstn(rstn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .rxd(rxd), .sck_in(ti),
		.timer_count_input(ti), .timer_toggle_output(tto),
		.port_c_pin2_out(p2o), .port_c_pin2_oe(p2e), .irq(irq));
	asr_rx_partner u_tx (.clk(clk), .txd(rxd));
	always #4 clk = ~clk;
	// Timer input holds each level six clocks; the counter cuts hangs.
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc % 6 == 5) ti <= ~ti;
		if (cyc == 40000) begin
			error_cnt = error_cnt + 1;
			conclude;
		end
	end
	// Answers are checked against the oldest note when they appear.
	always @(negedge clk) begin
		if (rvalid === 1'b1 && rready) begin
			e = ex_q.pop_front();
			chk("read", {e[41:34], rresp, rdata & e[73:42]},
				{e[41:32], e[31:0] & e[73:42]});
		end
		if (bvalid === 1'b1 && bready) chk("write", bresp, be_q.pop_front());
	end
	task automatic chk(input string n, input [41:0] s, x);
		begin
			n_tests = n_tests + 1;
			if (s !== x) begin
				error_cnt = error_cnt + 1;
				$display("CHECK FAILED %s exp %h seen %h", n, x, s);
			end
		end
	endtask
	// One access; a write offers address and data in the same cycle.
	task bus(input w, input [7:0] a, input [31:0] d, m, input [1:0] r);
		begin
			if (w) be_q.push_back(r);
			else ex_q.push_back({m, a, r, d});
			@(posedge clk);
			awaddr <= a;
			araddr <= a;
			wdata <= d;
			awvalid <= w;
			wvalid <= w;
			arvalid <= !w;
			bready <= w;
			rready <= !w;
			do begin
				@(negedge clk);
				ka = awvalid && awready === 1'b1;
				kw = wvalid && wready === 1'b1;
				ks = arvalid && arready === 1'b1;
				@(posedge clk);
				if (ka) awvalid <= 0;
				if (kw) wvalid <= 0;
				if (ks) arvalid <= 0;
			end while (awvalid && !ka || wvalid && !kw || arvalid && !ks);
			do @(negedge clk); while ((w ? bvalid : rvalid) !== 1'b1);
			@(posedge clk);
			bready <= 0;
			rready <= 0;
		end
	endtask
	// Frame in, then status, data and a raised interrupt, then clear.
	task frame(input [7:0] d, input [1:0] p, m, input [7:0] se, sm);
		begin
			u_tx.send(d, bt, p, m);
			bus(0, 8'h10, se, sm, 0);
			bus(0, 8'h0C, d, se[0] && m == 0 ? 8'hFF : 8'h0, 0);
			@(negedge clk);
			chk("irq", irq, 1);
			bus(1, 8'h10, 8'h3E, 0, 0);
			bus(1, 8'h18, 8'h07, 0, 0);
			repeat (2) @(negedge clk);
			chk("irq", irq, 0);
		end
	endtask
	function [31:0] lfsr(input [31:0] s);
		lfsr = {1'b0, s[31:1]} ^ (s[0] ? 32'h8020_0003 : 32'h0);
	endfunction
	task conclude;
		begin
			$display("errors %0d checks %0d", error_cnt, n_tests);
			if (error_cnt == 0 && n_tests > 0)
				$display("DONE - PASS");
			else
				$display("DONE - FAIL");
			$finish;
		end
	endtask
	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1;
		repeat (2) @(posedge clk);
		bus(0, 8'h04, 8'h43, 32'hFFFF_FFFF, 0);
		bus(0, 8'h08, 8'h01, 32'hFFFF_FFFF, 0);
		bus(0, 8'h24, 0, 32'hFFFF_FFFF, 2);
		bus(1, 8'h24, 0, 0, 2);
		rs = lfsr(rs);
		bus(1, 8'h04, rs[15:0], 0, 0);
		bus(0, 8'h04, rs[15:0], 32'hFFFF_FFFF, 0);
		bus(1, 8'h04, 0, 0, 0);
		bus(1, 8'h00, 8'h09, 0, 0);
		// A masked event keeps the line low; the next byte overruns.
		u_tx.send(rs[23:16], bt, 0, 0);
		repeat (2) @(negedge clk);
		chk("irq", irq, 0);
		bus(1, 8'h1C, 8'h07, 0, 0);
		frame(rs[7:0], 0, 0, 8'h13, 8'h7F);
		frame(8'hA5, 0, 1, 8'h06, 8'h3E);
		frame(8'hA5, 0, 0, 8'h01, 8'h7F); // Resend after error.
		frame(8'h5A, 0, 3, 8'h20, 8'h21);
		frame(8'h5A, 0, 0, 8'h01, 8'h7F);
		for (k = 0; k < 4; k++) begin
			bus(1, 8'h00, 8'h29 | (k % 2) * 64, 0, 0);
			frame(8'h3C, k % 2 + 1, k / 2 * 2, k / 2 ? 8'h0A : 8'h01,
				k / 2 ? 8'h3E : 8'h3F);
		end
		bus(1, 8'h00, 8'h0B, 0, 0);
		bus(0, 8'h10, 8'h40, 8'h40, 0);
		for (k = 1; k < 3; k++) begin
			bus(1, 8'h08, k, 0, 0);
			bus(1, 8'h00, 8'h0D, 0, 0);
			bt = 384 * k;
			frame(8'hC3 ^ k, 0, 0, 8'h01, 8'h7F);
		end
		bt = 16;
		bus(1, 8'h00, 8'h09, 0, 0);
		bus(1, 8'h20, 8'h03, 0, 0);
		repeat (4) begin
			@(negedge clk);
			chk("pin2", {p2e, p2o}, 2'b11);
		end
		bus(1, 8'h20, 0, 0, 0);
		@(negedge clk);
		chk("pin2", p2e, 0);
		conclude;
	end
endmodule // async_serial_receiver_clocking_tb_top
`default_nettype wire
